// [hdl/gst_defines.svh]
/*
  Timing and field constants of the self-test sequencer.
  Assumes a 100 MHz core clock and a one-millisecond timebase tick.
*/
`ifndef GST_DEFINES_SVH
`define GST_DEFINES_SVH

// Clock and timebase
`define GST_CLK_PERIOD_NS  10
`define GST_TICK_NS        1000000
`define GST_TICK_CYCLES    (`GST_TICK_NS / `GST_CLK_PERIOD_NS)
`define GST_PRE_W          17

// Delays in milliseconds, which is one timebase tick each, and the minutes, count and frequency they are built from
`define GST_FIRST_MS       1000
`define GST_PERIOD_MIN     90
`define GST_PERIOD_MS      (`GST_PERIOD_MIN * 60 * 1000)
`define GST_WINDOW_MS      66
`define GST_ATTEMPTS       4
`define GST_ATTEMPT_MS     (`GST_WINDOW_MS / `GST_ATTEMPTS)
`define GST_PHASE_MS       60
`define GST_ALARM_HIGH_MS  133
`define GST_ALARM_FREQ_MHZ 3750
`define GST_ALARM_HALF_MS  (1000000 / (2 * `GST_ALARM_FREQ_MHZ))

// Counter widths
`define GST_CNT_W          23
`define GST_SHORT_W        8

`endif

// [hdl/gst_pkg.sv]
/*
  Types shared by the self-test sequencer files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package gst_pkg;

  // One-hot sequencer states
  typedef enum logic [3:0] {
    ST_WAIT   = 4'h1,
    ST_ARM    = 4'h2,
    ST_INJECT = 4'h4,
    ST_EOL    = 4'h8
  } gst_state_t;

endpackage

// [hdl/gst_sequencer.sv]
/*
  Self-test sequencer of a ground-fault interrupter: schedules test cycles,
  drives fault injection and anode bias, and latches the end-of-life alarm.
  Assumes RST_N_I is the power-on reset from the supply monitor, and that
  the analog comparators deliver levels synchronous to CLK_I.
*/
`timescale 1ns/100ps
`default_nettype none
`include "gst_defines.svh"

module gst_sequencer #(
  parameter int unsigned TICK_CYCLES  = `GST_TICK_CYCLES,
  parameter int unsigned PERIOD_TICKS = `GST_PERIOD_MS
) (
  input  wire logic         CLK_I,
  input  wire logic         RST_N_I,
  input  wire logic         THYRISTOR_ANODE_SENSE_I,
  input  wire logic         PHASE_END_I,
  input  wire logic         PHASE_OK_I,
  input  wire logic         MANUAL_TEST_I,
  output var  logic         ANODE_BIAS_O,
  output var  logic         FAULT_PULSE_O,
  output var  logic         TEST_ACTIVE_O,
  output var  logic         TEST_PASS_O,
  output var  logic         PHASE_FAULT_O,
  output var  logic         END_OF_LIFE_ALARM_O,
  output var  gst_pkg::gst_state_t STATE_O
);
  import gst_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic                    tick;

  gst_state_t              state_reg;
  gst_state_t              state_next;
  logic [`GST_CNT_W-1:0]   wait_cnt_reg;
  logic [`GST_CNT_W-1:0]   wait_cnt_next;
  logic [`GST_SHORT_W-1:0] window_cnt_reg;
  logic [`GST_SHORT_W-1:0] window_cnt_next;
  logic [`GST_SHORT_W-1:0] attempt_cnt_reg;
  logic [`GST_SHORT_W-1:0] attempt_cnt_next;
  logic                    trig_reg;
  logic                    trig_next;
  logic                    bias_reg;
  logic                    bias_next;
  logic                    pulse_reg;
  logic                    pulse_next;
  logic                    active_reg;
  logic                    active_next;

  logic [`GST_SHORT_W-1:0] phase_cnt_reg;
  logic [`GST_SHORT_W-1:0] phase_cnt_next;
  logic                    phase_done_reg;
  logic                    phase_done_next;
  logic                    phase_fault_reg;
  logic                    phase_fault_next;
  logic                    phase_trip;

  logic [`GST_SHORT_W-1:0] blink_cnt_reg;
  logic [`GST_SHORT_W-1:0] blink_cnt_next;
  logic                    alarm_reg;
  logic                    alarm_next;

  ////////////////////////////////////////////////////////////////////////
  // Shared arithmetic

  // Counts down once per tick and rests at zero
  function automatic logic [`GST_CNT_W-1:0] count_down(
    input logic [`GST_CNT_W-1:0] v,
    input logic                  t
  );
    if (t && (v != '0)) begin
      count_down = v - `GST_CNT_W'(1);
    end else begin
      count_down = v;
    end
  endfunction

  function automatic logic [`GST_SHORT_W-1:0] count_short(
    input logic [`GST_SHORT_W-1:0] v,
    input logic                    t
  );
    count_short = `GST_SHORT_W'(count_down(`GST_CNT_W'(v), t));
  endfunction

  // True when a short counter has run out
  function automatic logic short_zero(
    input logic [`GST_SHORT_W-1:0] v
  );
    short_zero = (v == '0);
  endfunction

  // Sequencer is inside a test cycle
  function automatic logic in_test(
    input gst_state_t s
  );
    in_test = (s == ST_ARM) || (s == ST_INJECT);
  endfunction

  // Test stimulus may only stand while injecting
  function automatic logic stim_on(
    input gst_state_t s
  );
    stim_on = (s == ST_INJECT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Timebase

  // Every delay below counts this tick, so a slow tick only stretches time
  gst_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) gst_timebase_inst (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .tick_o  (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Phase pin continuity check

  always_comb begin
    phase_cnt_next   = count_short(phase_cnt_reg, tick);
    phase_done_next  = phase_done_reg;
    phase_fault_next = phase_fault_reg;
    phase_trip       = 1'b0;
    // The pin is judged once, when the timeout runs out
    if (!phase_done_reg && short_zero(phase_cnt_reg)) begin
      phase_done_next = 1'b1;
      if (!PHASE_OK_I) begin
        phase_fault_next = 1'b1;
        phase_trip       = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      phase_cnt_reg   <= `GST_SHORT_W'(`GST_PHASE_MS);
      phase_done_reg  <= 1'b0;
      phase_fault_reg <= 1'b0;
    end else begin
      phase_cnt_reg   <= phase_cnt_next;
      phase_done_reg  <= phase_done_next;
      phase_fault_reg <= phase_fault_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Test sequencer

  always_comb begin
    state_next       = state_reg;
    wait_cnt_next    = count_down(wait_cnt_reg, tick);
    window_cnt_next  = count_short(window_cnt_reg, tick);
    attempt_cnt_next = count_short(attempt_cnt_reg, tick);
    trig_next        = trig_reg;
    unique case (state_reg)
      ST_WAIT: begin
        if (wait_cnt_reg == '0) begin
          state_next       = ST_ARM;
          window_cnt_next  = `GST_SHORT_W'(`GST_WINDOW_MS);
          attempt_cnt_next = `GST_SHORT_W'(`GST_ATTEMPT_MS);
          // The pass flag stands until the next cycle starts
          trig_next        = 1'b0;
        end
      end
      ST_ARM: begin
        // The attempt timer keeps running across arming and injection
        if (short_zero(window_cnt_reg)) begin
          state_next = ST_EOL;
        end else if (PHASE_END_I) begin
          state_next = ST_INJECT;
        end else if (short_zero(attempt_cnt_reg)) begin
          attempt_cnt_next = `GST_SHORT_W'(`GST_ATTEMPT_MS);
        end
      end
      ST_INJECT: begin
        // A discharged anode means the thyristor fired: pass at once
        if (!THYRISTOR_ANODE_SENSE_I) begin
          trig_next     = 1'b1;
          state_next    = ST_WAIT;
          wait_cnt_next = `GST_CNT_W'(PERIOD_TICKS);
        end else if (short_zero(window_cnt_reg)) begin
          state_next = ST_EOL;
        end else if (short_zero(attempt_cnt_reg)) begin
          state_next       = ST_ARM;
          attempt_cnt_next = `GST_SHORT_W'(`GST_ATTEMPT_MS);
        end
      end
      ST_EOL: begin
        // A phase-pin fault can only be left by power-on reset
        if (MANUAL_TEST_I && !phase_fault_reg) begin
          state_next    = ST_WAIT;
          wait_cnt_next = `GST_CNT_W'(`GST_FIRST_MS);
        end
      end
      default: begin
        state_next    = ST_WAIT;
        wait_cnt_next = `GST_CNT_W'(`GST_FIRST_MS);
      end
    endcase
    if (phase_trip) begin
      state_next = ST_EOL;
    end
    // Only the test stimulus is driven; the trip path stays untouched
    bias_next   = stim_on(state_next);
    pulse_next  = stim_on(state_next);
    active_next = in_test(state_next);
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_reg       <= ST_WAIT;
      wait_cnt_reg    <= `GST_CNT_W'(`GST_FIRST_MS);
      window_cnt_reg  <= '0;
      attempt_cnt_reg <= '0;
      trig_reg        <= 1'b0;
      bias_reg        <= 1'b0;
      pulse_reg       <= 1'b0;
      active_reg      <= 1'b0;
    end else begin
      state_reg       <= state_next;
      wait_cnt_reg    <= wait_cnt_next;
      window_cnt_reg  <= window_cnt_next;
      attempt_cnt_reg <= attempt_cnt_next;
      trig_reg        <= trig_next;
      bias_reg        <= bias_next;
      pulse_reg       <= pulse_next;
      active_reg      <= active_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // End-of-life alarm blinker

  always_comb begin
    alarm_next     = 1'b0;
    blink_cnt_next = `GST_SHORT_W'(`GST_ALARM_HIGH_MS);
    if (state_next == ST_EOL) begin
      // Entry always starts with a full high phase
      if (state_reg != ST_EOL) begin
        alarm_next     = 1'b1;
        blink_cnt_next = `GST_SHORT_W'(`GST_ALARM_HIGH_MS);
      end else if (short_zero(blink_cnt_reg)) begin
        // Equal halves give the square wave
        alarm_next = !alarm_reg;
        if (alarm_reg) begin
          blink_cnt_next = `GST_SHORT_W'(`GST_ALARM_HALF_MS);
        end else begin
          blink_cnt_next = `GST_SHORT_W'(`GST_ALARM_HIGH_MS);
        end
      end else begin
        alarm_next     = alarm_reg;
        blink_cnt_next = count_short(blink_cnt_reg, tick);
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      alarm_reg     <= 1'b0;
      blink_cnt_reg <= `GST_SHORT_W'(`GST_ALARM_HIGH_MS);
    end else begin
      alarm_reg     <= alarm_next;
      blink_cnt_reg <= blink_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Registered outputs, so the far side never sees a decode glitch
  assign ANODE_BIAS_O        = bias_reg;
  assign FAULT_PULSE_O       = pulse_reg;
  assign TEST_ACTIVE_O       = active_reg;
  assign TEST_PASS_O         = trig_reg;
  assign PHASE_FAULT_O       = phase_fault_reg;
  assign END_OF_LIFE_ALARM_O = alarm_reg;
  assign STATE_O             = state_reg;

endmodule
`default_nettype wire

// [hdl/gst_timebase.sv]
/*
  Free-running prescaler giving a one-cycle tick once per millisecond.
  Assumes the core clock and the power-on reset of the sequencer.
*/
`timescale 1ns/100ps
`default_nettype none
`include "gst_defines.svh"

module gst_timebase #(
  parameter int unsigned TICK_CYCLES = `GST_TICK_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output var  logic tick_o
);

  logic [`GST_PRE_W-1:0] pre_reg;
  logic [`GST_PRE_W-1:0] pre_next;
  logic                  tick_reg;
  logic                  tick_next;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    if (pre_reg == `GST_PRE_W'(TICK_CYCLES - 1)) begin
      pre_next  = '0;
      tick_next = 1'b1;
    end else begin
      pre_next  = pre_reg + `GST_PRE_W'(1);
      tick_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pre_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule
`default_nettype wire

// [testbench/gst_fault_chain_model.sv]
/* Far side: phase detector, thyristor and anode sense line.
   Assumes the bench sets the firing delay; 0 never fires. */
`timescale 1ns/100ps
`default_nettype none
module gst_fault_chain_model (
  input  wire logic       clk_i,
  input  wire logic       bias_i,
  input  wire logic       pulse_i,
  input  wire logic [7:0] fire_dly_i,
  output var  logic       phase_end_o = 1'b0,
  output var  logic       sense_o = 1'b1
);
  logic [4:0] ph_reg  = 5'h00;
  logic [7:0] cnt_reg = 8'h00;
  always @(posedge clk_i) begin
    ph_reg      <= (ph_reg == 5'h13) ? 5'h00 : ph_reg + 5'h01;
    // Fires only while bias and fault current both stand
    cnt_reg     <= (bias_i && pulse_i) ? cnt_reg + 8'h01 : 8'h00;
    phase_end_o <= #1 ph_reg == 5'h00;
    // The pin clamp holds the line high while unbiased, so no false fire on entry
    sense_o     <= #1 bias_i ? !(fire_dly_i != 8'h00 && cnt_reg >= fire_dly_i) : 1'b1;
  end
endmodule
`default_nettype wire

// [testbench/gst_sequencer_checker.sv]
/* Port assertions of gst_sequencer.
   Assumes the bind below hands on the design's parameters. */
`timescale 1ns/100ps
`default_nettype none
module gst_sequencer_checker
  import gst_pkg::*;
#(
  parameter int unsigned TICK_CYCLES  = 100000,
  parameter int unsigned PERIOD_TICKS = 5400000
) (
  input wire logic                CLK_I,
  input wire logic                RST_N_I,
  input wire logic                THYRISTOR_ANODE_SENSE_I,
  input wire logic                MANUAL_TEST_I,
  input wire logic                ANODE_BIAS_O,
  input wire logic                FAULT_PULSE_O,
  input wire logic                TEST_ACTIVE_O,
  input wire logic                TEST_PASS_O,
  input wire logic                PHASE_FAULT_O,
  input wire logic                END_OF_LIFE_ALARM_O,
  input wire gst_pkg::gst_state_t STATE_O
);
  // Blink phases start off tick edges, so one tick of slack each way
  localparam int HMIN = 132 * TICK_CYCLES;
  localparam int HMAX = 134 * TICK_CYCLES + 2;
  logic end_of_life_alarm;
  logic alq_reg;
  logic bq_reg;
  int   run_reg;
  int   inj_reg;
  assign end_of_life_alarm = STATE_O == ST_EOL;
  always_ff @(posedge CLK_I) begin
    alq_reg <= END_OF_LIFE_ALARM_O;
    bq_reg  <= ANODE_BIAS_O;
    run_reg <= (!RST_N_I || !end_of_life_alarm || alq_reg != END_OF_LIFE_ALARM_O) ? 0 : run_reg + 1;
    inj_reg <= (!RST_N_I || !TEST_ACTIVE_O) ? 0 : inj_reg + int'(ANODE_BIAS_O && !bq_reg);
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  sequence enter_eol;
    $rose(end_of_life_alarm);
  endsequence
  a_reset_clears: assert property (disable iff (1'b0)
    !RST_N_I |=> STATE_O == ST_WAIT && !END_OF_LIFE_ALARM_O && !PHASE_FAULT_O && !TEST_PASS_O)
    else $error("state kept through reset");
  a_trigger_stops: assert property (
    STATE_O == ST_INJECT && !THYRISTOR_ANODE_SENSE_I |=> !ANODE_BIAS_O && !FAULT_PULSE_O && TEST_PASS_O)
    else $error("injection not stopped on trigger");
  a_eol_alarm_on: assert property (enter_eol |-> END_OF_LIFE_ALARM_O && !ANODE_BIAS_O)
    else $error("alarm not raised on entry");
  a_alarm_only_eol: assert property (END_OF_LIFE_ALARM_O |-> end_of_life_alarm)
    else $error("alarm outside end-of-life");
  a_high_phase: assert property (
    end_of_life_alarm && $fell(END_OF_LIFE_ALARM_O) |-> run_reg >= HMIN && run_reg <= HMAX)
    else $error("alarm high phase length wrong");
  a_blink_runs: assert property (end_of_life_alarm |-> run_reg <= HMAX)
    else $error("alarm stopped blinking");
  a_manual_clears: assert property (
    end_of_life_alarm && MANUAL_TEST_I && !PHASE_FAULT_O |=> STATE_O == ST_WAIT && !END_OF_LIFE_ALARM_O)
    else $error("manual test did not clear alarm");
  a_manual_ignored: assert property (end_of_life_alarm && PHASE_FAULT_O && MANUAL_TEST_I |=> end_of_life_alarm)
    else $error("phase alarm cleared by manual test");
  a_four_attempts: assert property (enter_eol ##0 !PHASE_FAULT_O |-> inj_reg >= 4)
    else $error("too few attempts in window");
  a_phase_sticky: assert property (PHASE_FAULT_O |-> end_of_life_alarm)
    else $error("phase fault without alarm state");
  a_stim_in_test: assert property (
    ANODE_BIAS_O || FAULT_PULSE_O |-> STATE_O == ST_INJECT && TEST_ACTIVE_O && ANODE_BIAS_O == FAULT_PULSE_O)
    else $error("test stimulus outside injection");
endmodule
bind gst_sequencer gst_sequencer_checker #(
  .TICK_CYCLES (TICK_CYCLES),
  .PERIOD_TICKS(PERIOD_TICKS)
) gst_sequencer_checker_inst (.CLK_I, .RST_N_I, .THYRISTOR_ANODE_SENSE_I, .MANUAL_TEST_I, .ANODE_BIAS_O,
  .FAULT_PULSE_O, .TEST_ACTIVE_O, .TEST_PASS_O, .PHASE_FAULT_O, .END_OF_LIFE_ALARM_O, .STATE_O);
`default_nettype wire

// [testbench/gst_sequencer_tb_top.sv]
/* Self-checking bench of gst_sequencer with the far-side model.
   Assumes the bound checker and a shortened tick. */
`timescale 1ns/100ps
`default_nettype none
module gst_sequencer_tb_top;
  import gst_pkg::*;
  localparam int TC  = 10;
  localparam int TOL = 12;
  typedef struct {
    logic [5:0] sig;
    int         gap;
  } gst_note_t;
  logic       clk    = 1'b0;
  logic       rst_n  = 1'b0;
  logic       ph_ok  = 1'b1;
  logic       manual = 1'b0;
  logic [7:0] dly    = 8'h05;
  logic       sense, ph_end, bias, pulse, active, pass, pfault, alarm;
  gst_state_t state;
  logic [5:0] sig, sig_q;
  int         cyc, errors = 0, tests_run = 0;
  gst_note_t  q[$];
  ////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  // Watched word: eol, wait, active, alarm, pass, phase fault
  assign sig = {state[3], state[0], active, alarm, pass, pfault};
  gst_sequencer #(.TICK_CYCLES(TC), .PERIOD_TICKS(50)) gst_sequencer_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .THYRISTOR_ANODE_SENSE_I(sense), .PHASE_END_I(ph_end),
    .PHASE_OK_I(ph_ok), .MANUAL_TEST_I(manual), .ANODE_BIAS_O(bias), .FAULT_PULSE_O(pulse),
    .TEST_ACTIVE_O(active), .TEST_PASS_O(pass), .PHASE_FAULT_O(pfault),
    .END_OF_LIFE_ALARM_O(alarm), .STATE_O(state));
  gst_fault_chain_model gst_fault_chain_model_inst (.clk_i(clk), .bias_i(bias), .pulse_i(pulse),
    .fire_dly_i(dly), .phase_end_o(ph_end), .sense_o(sense));
  // Each change of the word takes the oldest note; sampled mid-cycle where outputs are settled
  always @(negedge clk) begin
    gst_note_t n;
    if (!rst_n) begin
      cyc   = 0;
      sig_q = sig;
    end else begin
      cyc = cyc + 1;
      if (sig !== sig_q) begin
        sig_q = sig;
        n = '{6'h3f, -1};
        if (q.size() != 0) begin
          n = q.pop_front();
        end
        tests_run++;
        if (sig !== n.sig || (n.gap >= 0 && (cyc < n.gap - TOL || cyc > n.gap + TOL))) begin
          errors++;
          $display("Error at %0t: got %h/%h expected %h/%h", $time, sig, cyc, n.sig, n.gap);
        end
        cyc = 0;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic note(input logic [5:0] s, input int g);
    q.push_back('{s, g});
  endtask
  task automatic drain();
    int k;
    for (k = 0; k < 40000 && q.size() != 0; k++) @(posedge clk);
    if (q.size() != 0) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, q.size(), 0);
      report_and_stop();
    end
  endtask
  task automatic power_on(input logic ok);
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    ph_ok = ok;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
  endtask
  task automatic press();
    @(posedge clk);
    #1;
    manual = 1'b1;
    @(posedge clk);
    #1;
    manual = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h58e81601));
    // Short enough to fire inside the shortest injection of an attempt
    dly = 8'($urandom_range(100, 1));
    power_on(1'b1);
    note(6'h08, 1000 * TC);
    note(6'h12, -1);
    note(6'h08, 50 * TC);
    note(6'h12, -1);
    drain();
    $display("Test pass and periodic retest done");
    // Slow trigger: every attempt times out before the thyristor fires
    dly = 8'($urandom_range(255, 170));
    note(6'h08, 50 * TC);
    note(6'h24, 66 * TC);
    note(6'h20, 133 * TC);
    note(6'h24, 133 * TC);
    drain();
    dly = 8'($urandom_range(100, 1));
    note(6'h10, -1);
    note(6'h08, 1000 * TC);
    note(6'h12, -1);
    press();
    drain();
    $display("Test failed window and manual clear done");
    power_on(1'b0);
    note(6'h25, 60 * TC);
    note(6'h21, 133 * TC);
    drain();
    note(6'h25, 133 * TC);
    press();
    drain();
    power_on(1'b1);
    note(6'h08, 1000 * TC);
    note(6'h12, -1);
    drain();
    $display("Test phase fault and power-on clear done");
    report_and_stop();
  end
endmodule
`default_nettype wire
